// file: rtl/led_ctrl_pkg.sv
/*
  Constants for the LED manual control block: register offset, field
  positions, blink rate reset value and blink timing.
  Assumes a 20 MHz core clock.
*/
package led_ctrl_pkg;

  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned ADDR_W         = 5;
  localparam int unsigned DATA_W         = 16;
  localparam logic [4:0]  LED_CTRL_ADDR  = 5'h18;

  localparam int unsigned RATE_HI        = 10;
  localparam int unsigned RATE_LO        = 9;
  localparam int unsigned POL_SPEED      = 8;
  localparam int unsigned POL_LINK       = 7;
  localparam int unsigned POL_ACT        = 6;
  localparam int unsigned OVR_SPEED      = 5;
  localparam int unsigned OVR_LINK       = 4;
  localparam int unsigned OVR_ACT        = 3;
  localparam int unsigned VAL_SPEED      = 2;
  localparam int unsigned VAL_LINK       = 1;
  localparam int unsigned VAL_ACT        = 0;

  localparam logic [1:0]  RATE_RESET     = 2'h2;

  localparam int unsigned RATE0_MS       = 50;
  localparam int unsigned RATE1_MS       = 100;
  localparam int unsigned RATE2_MS       = 200;
  localparam int unsigned RATE3_MS       = 500;

  localparam int unsigned TICK_HZ        = 1000;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / TICK_HZ;
  localparam int unsigned TICK_W         = 15;
  localparam int unsigned MS_W           = 9;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [MS_W-1:0]   RATE0_LAST = MS_W'(RATE0_MS - 1);
  localparam logic [MS_W-1:0]   RATE1_LAST = MS_W'(RATE1_MS - 1);
  localparam logic [MS_W-1:0]   RATE2_LAST = MS_W'(RATE2_MS - 1);
  localparam logic [MS_W-1:0]   RATE3_LAST = MS_W'(RATE3_MS - 1);

endpackage

// file: rtl/led_sync2.sv
/*
  Two flip-flop synchroniser for a bundle of slow pin levels.
  Assumes inputs are quasi-static or asynchronous to the clock.
*/
`timescale 1ns/100ps
`default_nettype none
module led_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             core_clk,  // Core clock
  input  wire logic             sys_rst,   // Async reset, high
  input  wire logic [WIDTH-1:0] async_in,  // Pin levels
  output logic      [WIDTH-1:0] sync_out   // Synchronised levels
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  always_comb
  begin
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.sync;

endmodule
`default_nettype wire

// file: rtl/led_blink_gen.sv
/*
  Blink square wave generator. A 1 ms tick enable is derived from the
  core clock; the phase toggles every selected number of milliseconds.
  Assumes a 20 MHz core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module led_blink_gen (
  input  wire logic       core_clk,    // Core clock
  input  wire logic       sys_rst,     // Async reset, high
  input  wire logic [1:0] rate_sel,    // Blink rate code
  output logic            blink_phase  // Blink square wave
);

  typedef struct packed {
    logic [led_ctrl_pkg::TICK_W-1:0] tick_cnt;
    logic [led_ctrl_pkg::MS_W-1:0]   ms_cnt;
    logic                            phase;
  } blink_state_t;

  blink_state_t s_q;
  blink_state_t s_d;
  logic [led_ctrl_pkg::MS_W-1:0] ms_last;

  always_comb
  begin
    case (rate_sel)
      2'h0:    ms_last = led_ctrl_pkg::RATE0_LAST;
      2'h1:    ms_last = led_ctrl_pkg::RATE1_LAST;
      2'h2:    ms_last = led_ctrl_pkg::RATE2_LAST;
      default: ms_last = led_ctrl_pkg::RATE3_LAST;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    if (s_q.tick_cnt == led_ctrl_pkg::TICK_LAST)
    begin
      s_d.tick_cnt = '0;
      // A rate change to a shorter period ends the current phase at the next tick if the count already reached its end.
      if (s_q.ms_cnt >= ms_last)
      begin
        s_d.ms_cnt = '0;
        s_d.phase  = ~s_q.phase;
      end
      else
      begin
        s_d.ms_cnt = s_q.ms_cnt + 1'b1;
      end
    end
    else
    begin
      s_d.tick_cnt = s_q.tick_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign blink_phase = s_q.phase;

endmodule
`default_nettype wire

// file: rtl/led_manual_control.sv
/*
  LED manual control register and LED pin drive for speed, link and
  activity indicators, with blink rate, strapped polarity and override.
  Assumes status inputs are on core_clk; strap pins are asynchronous.
*/
// Function
// - Bits 15:11 ignore writes, read zero
// - Rate code selects 50/100/200/500 ms blink
// - Blink rate resets to code 10
// - Speed polarity from strap, software overrides
// - Link polarity from strap, software overrides
// - Activity polarity from strap, software overrides
// - Speed override drives stored speed value
// - Link override drives stored link value
// - Activity override drives stored activity value
// - Three forced values, reset to zero
`timescale 1ns/100ps
`default_nettype none
module led_manual_control (
  input  wire logic                              core_clk,               // Core clock
  input  wire logic                              sys_rst,                // Async reset, high
  input  wire logic [led_ctrl_pkg::ADDR_W-1:0]   reg_addr,               // Register address
  input  wire logic [led_ctrl_pkg::DATA_W-1:0]   reg_wdata,              // Write data
  input  wire logic                              reg_wr,                 // Write strobe
  input  wire logic                              reg_rd,                 // Read strobe
  output logic      [led_ctrl_pkg::DATA_W-1:0]   reg_rdata,              // Read data
  input  wire logic [2:0]                        strap_pol,              // Straps: speed,link,act
  input  wire logic                              speed_100,              // Speed is 100 Mb/s
  input  wire logic                              link_up,                // Link is good
  input  wire logic                              activity,               // Activity seen
  input  wire logic                              blink_enable,           // Link LED blinks on act
  output logic                                   speed_indicator_pin,    // Speed LED pin
  output logic                                   link_indicator_pin,     // Link LED pin
  output logic                                   activity_indicator_pin  // Activity LED pin
);

  typedef struct packed {
    logic [1:0]                    rate;
    logic [2:0]                    pol;
    logic [2:0]                    ovr;
    logic [2:0]                    val;
    logic                          strap_armed;
    logic [1:0]                    strap_ready;
    logic [led_ctrl_pkg::DATA_W-1:0] rdata;
    logic [2:0]                    pins;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  logic [2:0] strap_sync;
  logic       blink_phase;
  logic [2:0] normal_on;
  logic [2:0] logical_on;

  led_sync2 #(
    .WIDTH (3)
  ) u_strap_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (strap_pol),
    .sync_out (strap_sync)
  );

  led_blink_gen u_blink (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .rate_sel    (s_q.rate),
    .blink_phase (blink_phase)
  );

  function automatic logic [led_ctrl_pkg::DATA_W-1:0] pack_reg(input ctrl_state_t s);
    logic [led_ctrl_pkg::DATA_W-1:0] r;
    r = '0;
    r[led_ctrl_pkg::RATE_HI:led_ctrl_pkg::RATE_LO] = s.rate;
    r[led_ctrl_pkg::POL_SPEED]                     = s.pol[2];
    r[led_ctrl_pkg::POL_LINK]                      = s.pol[1];
    r[led_ctrl_pkg::POL_ACT]                       = s.pol[0];
    r[led_ctrl_pkg::OVR_SPEED]                     = s.ovr[2];
    r[led_ctrl_pkg::OVR_LINK]                      = s.ovr[1];
    r[led_ctrl_pkg::OVR_ACT]                       = s.ovr[0];
    r[led_ctrl_pkg::VAL_SPEED]                     = s.val[2];
    r[led_ctrl_pkg::VAL_LINK]                      = s.val[1];
    r[led_ctrl_pkg::VAL_ACT]                       = s.val[0];
    return r;
  endfunction

  always_comb
  begin
    normal_on[2] = link_up & speed_100;
    normal_on[1] = blink_enable ? (link_up & ~(activity & blink_phase)) : link_up;
    normal_on[0] = activity & blink_phase;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_led
      // Override picks the stored value, else the normal indication.
      assign logical_on[g] = s_q.ovr[g] ? s_q.val[g] : normal_on[g];
    end
  endgenerate

  always_comb
  begin
    s_d       = s_q;
    s_d.rdata = '0;
    s_d.strap_ready = {s_q.strap_ready[0], 1'b1};
    // Straps are caught once, on the third edge after release, when both
    // synchroniser stages hold the pin level rather than their reset zero.
    if (!s_q.strap_armed && s_q.strap_ready[1])
    begin
      s_d.pol         = strap_sync;
      s_d.strap_armed = 1'b1;
    end
    if (reg_wr && reg_addr == led_ctrl_pkg::LED_CTRL_ADDR)
    begin
      s_d.rate   = reg_wdata[led_ctrl_pkg::RATE_HI:led_ctrl_pkg::RATE_LO];
      s_d.pol[2] = reg_wdata[led_ctrl_pkg::POL_SPEED];
      s_d.pol[1] = reg_wdata[led_ctrl_pkg::POL_LINK];
      s_d.pol[0] = reg_wdata[led_ctrl_pkg::POL_ACT];
      s_d.ovr[2] = reg_wdata[led_ctrl_pkg::OVR_SPEED];
      s_d.ovr[1] = reg_wdata[led_ctrl_pkg::OVR_LINK];
      s_d.ovr[0] = reg_wdata[led_ctrl_pkg::OVR_ACT];
      s_d.val[2] = reg_wdata[led_ctrl_pkg::VAL_SPEED];
      s_d.val[1] = reg_wdata[led_ctrl_pkg::VAL_LINK];
      s_d.val[0] = reg_wdata[led_ctrl_pkg::VAL_ACT];
    end
    if (reg_rd)
    begin
      if (reg_addr == led_ctrl_pkg::LED_CTRL_ADDR)
      begin
        s_d.rdata = pack_reg(s_q);
      end
      else
      begin
        s_d.rdata = '0;
      end
    end
    // Active high shows the state as is; active low inverts it.
    s_d.pins = ~(logical_on ^ s_q.pol);
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q      <= '0;
      s_q.rate <= led_ctrl_pkg::RATE_RESET;
      s_q.pins <= 3'h7;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata              = s_q.rdata;
  assign speed_indicator_pin    = s_q.pins[2];
  assign link_indicator_pin     = s_q.pins[1];
  assign activity_indicator_pin = s_q.pins[0];

endmodule
`default_nettype wire

// file: verif/led_ctrl_monitor.sv
/* Port checker for the LED manual control block.
   Assumes a bind to led_manual_control and no write in the first 3 edges after reset. */
`timescale 1ns/100ps
`default_nettype none
module led_ctrl_monitor (
  input wire logic        core_clk,               // Clock
  input wire logic        sys_rst,                // Reset
  input wire logic [4:0]  reg_addr,               // Address
  input wire logic [15:0] reg_wdata,              // Write data
  input wire logic        reg_wr,                 // Write strobe
  input wire logic        reg_rd,                 // Read strobe
  input wire logic [15:0] reg_rdata,              // Read data
  input wire logic        speed_100,              // Speed status
  input wire logic        link_up,                // Link status
  input wire logic        speed_indicator_pin,    // Speed pin
  input wire logic        link_indicator_pin,     // Link pin
  input wire logic        activity_indicator_pin  // Activity pin
);
  logic wr_seen_q;
  logic hit_wr;
  assign hit_wr = reg_wr && reg_addr == led_ctrl_pkg::LED_CTRL_ADDR;
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      wr_seen_q <= 1'b0;
    else if (hit_wr)
      wr_seen_q <= 1'b1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_rsv_zero : assert property (reg_rdata[15:11] == 5'h00)
    else $error("reserved read bits not zero");
  chk_miss_zero : assert property (reg_rd && reg_addr != led_ctrl_pkg::LED_CTRL_ADDR
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  chk_write_read_back : assert property (hit_wr ##1 (reg_rd && reg_addr == 5'h18)
    |=> reg_rdata == {5'h00, $past(reg_wdata[10:0], 2)}) else $error("read back differs");
  chk_reset_vals : assert property (reg_rd && reg_addr == 5'h18 && !wr_seen_q
    |=> reg_rdata[10:9] == 2'h2 && reg_rdata[5:0] == 6'h00) else $error("reset value wrong");
  chk_speed_forced : assert property (hit_wr && reg_wdata[5] |-> ##2
    speed_indicator_pin == ($past(reg_wdata[2], 2) ~^ $past(reg_wdata[8], 2)))
    else $error("forced speed pin wrong");
  chk_link_forced : assert property (hit_wr && reg_wdata[4] |-> ##2
    link_indicator_pin == ($past(reg_wdata[1], 2) ~^ $past(reg_wdata[7], 2)))
    else $error("forced link pin wrong");
  chk_act_forced : assert property (hit_wr && reg_wdata[3] |-> ##2
    activity_indicator_pin == ($past(reg_wdata[0], 2) ~^ $past(reg_wdata[6], 2)))
    else $error("forced activity pin wrong");
  chk_speed_normal : assert property (hit_wr && !reg_wdata[5] ##1
    (!reg_wr && $stable(link_up) && $stable(speed_100))[*3] |->
    speed_indicator_pin == ((link_up && speed_100) ~^ $past(reg_wdata[8], 3)))
    else $error("normal speed pin wrong");
  cov_force_all : cover property (hit_wr && reg_wdata[5:3] == 3'h7);
  cov_read_hit : cover property (reg_rd && reg_addr == 5'h18);
  cov_read_miss : cover property (reg_rd && reg_addr != 5'h18);
endmodule
bind led_manual_control led_ctrl_monitor mon (.core_clk(core_clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .speed_100(speed_100), .link_up(link_up),
  .speed_indicator_pin(speed_indicator_pin), .link_indicator_pin(link_indicator_pin),
  .activity_indicator_pin(activity_indicator_pin));
`default_nettype wire

// file: verif/led_lamps.sv
/* Three indicator lamps hanging on the LED pins.
   Assumes board_pol tells how each lamp is wired: 1 lights on a high pin. */
`timescale 1ns/100ps
`default_nettype none
module led_lamps (
  input  wire logic       speed_pin,  // Speed pin
  input  wire logic       link_pin,   // Link pin
  input  wire logic       act_pin,    // Activity pin
  input  wire logic [2:0] board_pol,  // Lamp wiring
  output logic      [2:0] lit         // Lit: speed, link, act
);
  assign lit = {speed_pin, link_pin, act_pin} ~^ board_pol;
endmodule
`default_nettype wire

// file: verif/testbench.sv
/* Register and pin tests for the LED manual control block.
   Assumes a 20 MHz clock and lamps wired to match the programmed polarity. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        core_clk, sys_rst, reg_wr, reg_rd, speed_100, link_up, activity, blink_enable;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_val;
  logic [2:0]  strap_pol, board_pol, lit;
  logic        spd_pin, lnk_pin, act_pin;
  int          err_total, total_checks, k;
  led_manual_control uut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .strap_pol(strap_pol), .speed_100(speed_100), .link_up(link_up), .activity(activity),
    .blink_enable(blink_enable), .speed_indicator_pin(spd_pin),
    .link_indicator_pin(lnk_pin), .activity_indicator_pin(act_pin));
  led_lamps lamps (.speed_pin(spd_pin), .link_pin(lnk_pin), .act_pin(act_pin),
    .board_pol(board_pol), .lit(lit));
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic finish_test;
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_lit(input logic [2:0] e);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    total_checks++;
    if (lit !== e)
    begin
      err_total++;
      $display("MISMATCH lamps exp %h got %h", e, lit);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    rd_val = reg_rdata;
  endtask
  task automatic do_reset;
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask
  initial
  begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    finish_test();
  end
  initial
  begin
    {sys_rst, reg_wr, reg_rd, speed_100, link_up, activity, blink_enable} = 7'h40;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    strap_pol = 3'h5;
    board_pol = 3'h7;
    do_reset();
    rd(5'h18);
    chk16("reset", 16'h0540, rd_val);
    wr(5'h18, 16'hFFFF);
    rd(5'h18);
    chk16("reserved", 16'h07FF, rd_val);
    for (k = 0; k < 4; k++)
    begin
      wr(5'h18, 16'(k) << 9);
      rd(5'h18);
      chk16("rate", 16'(k) << 9, rd_val);
    end
    for (k = 0; k < 8; k++)
    begin
      board_pol = k[2:0];
      wr(5'h18, {7'h00, k[2:0], 3'h7, ~k[0], k[2], k[1]});
      chk_lit({~k[0], k[2], k[1]});
    end
    board_pol = 3'h7;
    @(posedge core_clk);
    link_up <= 1'b1;
    speed_100 <= 1'b1;
    wr(5'h18, 16'h01C0);
    chk_lit(3'h6);
    @(posedge core_clk);
    speed_100 <= 1'b0;
    chk_lit(3'h2);
    wr(5'h19, 16'h0000);
    rd(5'h18);
    chk16("kept", 16'h01C0, rd_val);
    rd(5'h19);
    chk16("unmapped", 16'h0000, rd_val);
    @(posedge core_clk);
    strap_pol <= 3'h2;
    board_pol = 3'h2;
    do_reset();
    rd(5'h18);
    chk16("strap", 16'h0480, rd_val);
    chk_lit(3'h2);
    @(posedge core_clk);
    activity <= 1'b1;
    blink_enable <= 1'b1;
    chk_lit(3'h2);
    finish_test();
  end
endmodule
`default_nettype wire
